// ---- rtl/tmr_gate_pkg.sv ----
// Shared constants for the byte timer, shared prescaler and gate logic.
// Assumes a single pclk domain at 25 MHz with an APB3 slave port.
package tmr_gate_pkg;
  localparam logic [11:0] OPT_OFS = 12'h000;
  localparam logic [11:0] CNT_OFS = 12'h004;
  localparam logic [11:0] ICR_OFS = 12'h008;
  localparam logic [11:0] GCR_OFS = 12'h00C;
  localparam logic [11:0] T3_OFS = 12'h010;
  localparam logic [11:0] CMD_OFS = 12'h014;
  localparam logic [11:0] STAT_OFS = 12'h018;
  // Option register fields
  localparam int PS_LSB = 0;
  localparam int PSA_BIT = 3;
  localparam int CS_BIT = 5;
  // Interrupt control fields
  localparam int OVF_FLAG_BIT = 2;
  localparam int OVF_IE_BIT = 5;
  // Gate control fields
  localparam int GSS_LSB = 0;
  localparam int GPOL_BIT = 6;
  localparam int GE_BIT = 7;
  localparam int ON_BIT = 8;
  // Third timer register fields
  localparam int T3_PER_LSB = 0;
  localparam int T3_ON_BIT = 16;
  // Command register bits (write one)
  localparam int CMD_WDCLR_BIT = 0;
  // Reset values
  localparam logic [7:0] OPT_RST = 8'hFF;
  localparam logic [7:0] PER_RST = 8'hFF;
  localparam logic [8:0] GCR_RST = 9'h000;
  // Watchdog base period in microseconds, converted to cycles, before the prescaler
  localparam int WDT_BASE_US = 18;
  localparam int CLK_MHZ = 25;
  localparam int WDT_BASE_CYC = WDT_BASE_US * CLK_MHZ;
  typedef enum logic [1:0] {GS_PIN, GS_BYTE_OVF, GS_T3_MATCH, GS_WDT_OVF} gate_src_t;
endpackage : tmr_gate_pkg

// ---- rtl/edge_sync.sv ----
// Two-stage synchroniser with rising-edge pulse output.
// Assumes the input is asynchronous to clk.
module edge_sync (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic async_in, // Signal from another domain
  output logic level, // Synchronised level
  output logic rise // One-cycle pulse on rising edge
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
endmodule : edge_sync

// ---- rtl/tmr_gate.sv ----
// Byte timer with shared watchdog prescaler, plus gate control for a second timer.
// Assumes an APB3 master on pclk; pins are asynchronous and synchronised here.
// Notes on behaviour
// - One prescaler, timer or watchdog; assign bit 0 selects the timer.
// - Timer prescale ratios 1:2 up to 1:256 from three-bit select.
// - Assign prescaler to watchdog for 1:1 timer counting.
// - Prescaler hidden; count register writes clear it when assigned to timer.
// - Watchdog clear also clears prescaler while assigned to watchdog.
// - Rollover FFh to 00h always sets overflow flag.
// - Only software clears flag; interrupt request needs enable bit.
// - Timer frozen during sleep, so no wake from its overflow.
// - External clock edges synchronised to instruction clock phases Q2 and Q4.
// - Second timer counts freely unless gate enable bit set.
// - Gate active counts on clock rising edge; inactive holds.
// - Polarity 0 counts on gate low; polarity 1 on gate high.
// - Source select: pin, timer overflow, third timer match, watchdog overflow.
// - Byte timer rollover makes a rising pulse for the gate.
// - Third timer resets to 00h after period match, pulsing the gate.
// - Gate on watchdog source powers watchdog regardless of timer on bit.
// - Prescaler settings still set watchdog interval when assigned to it; changing mid-measure is unsafe.
// - Gate-powered watchdog gives no reset or wake by itself.
module tmr_gate
  import tmr_gate_pkg::*;
(
  input wire logic pclk, // APB clock, 25 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic external_count_clock_pin, // External count clock
  input wire logic gate_input_pin, // External gate pin
  input wire logic second_clk_pin, // Second timer clock source
  input wire logic sleep_mode, // Core in sleep
  input wire logic wdt_config_en, // Watchdog enabled by configuration
  output logic byte_timer_irq, // Overflow interrupt request
  output logic wdt_osc_on, // Watchdog oscillator request
  output logic wdt_timeout, // Watchdog reset or wake request
  output logic [15:0] second_count // Second timer count
);
  logic [7:0] opt_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic flag_q;
  logic ie_q;
  logic [8:0] gcr_q;
  logic [7:0] per_q;
  logic [7:0] t3_q;
  logic t3_on_q;
  logic [7:0] psc_q;
  logic [15:0] wdt_base_q;
  logic [7:0] wdt_cnt_q;
  logic [1:0] phase_q;
  logic [15:0] sec_q;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic wd_clr;
  logic prescaler_assign_bit;
  logic ext_lvl;
  logic ext_rise;
  logic pin_lvl;
  logic sclk_rise;
  logic timer_src_tick;
  logic psc_out;
  logic timer_inc;
  logic overflow;
  logic t3_reset;
  logic wdt_run;
  logic wdt_tick;
  logic wdt_ovf;
  logic ovf_q;
  logic match_q;
  logic wovf_q;
  logic ovf_rise;
  logic match_rise;
  logic wovf_rise;
  logic gate_sel;
  logic gate_active;
  logic sleep_q;
  logic [7:0] ratio_mask;
  logic t3_tick;

  // APB decode
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      OPT_OFS, CNT_OFS, ICR_OFS, GCR_OFS, T3_OFS, CMD_OFS, STAT_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        OPT_OFS: prdata[7:0] <= opt_q;
        CNT_OFS: prdata[7:0] <= cnt_q;
        ICR_OFS: begin
          prdata[OVF_FLAG_BIT] <= flag_q;
          prdata[OVF_IE_BIT] <= ie_q;
        end
        GCR_OFS: prdata[8:0] <= gcr_q;
        T3_OFS: begin
          prdata[7:0] <= per_q;
          prdata[15:8] <= t3_q;
          prdata[T3_ON_BIT] <= t3_on_q;
        end
        STAT_OFS: prdata[15:0] <= sec_q;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign wd_clr = wr_en & (paddr == CMD_OFS) & pwdata[CMD_WDCLR_BIT];
  assign prescaler_assign_bit = opt_q[PSA_BIT];

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_q <= OPT_RST;
      gcr_q <= GCR_RST;
      ie_q <= 1'b0;
      per_q <= PER_RST;
      t3_on_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == OPT_OFS) opt_q <= pwdata[7:0];
      if (paddr == GCR_OFS) gcr_q <= pwdata[8:0];
      if (paddr == ICR_OFS) ie_q <= pwdata[OVF_IE_BIT];
      if (paddr == T3_OFS) begin
        per_q <= pwdata[7:0];
        t3_on_q <= pwdata[T3_ON_BIT];
      end
    end
  end

  // Pin synchronisers
  edge_sync u_ext (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(external_count_clock_pin),
    .level(ext_lvl),
    .rise(ext_rise)
  );
  edge_sync u_gpin (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(gate_input_pin),
    .level(pin_lvl),
    .rise()
  );
  edge_sync u_sclk (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(second_clk_pin),
    .level(),
    .rise(sclk_rise)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sleep_q <= 1'b0;
    else sleep_q <= sleep_mode;
  end

  // Instruction clock phases Q1..Q4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase_q <= 2'd0;
    else phase_q <= phase_q + 2'd1;
  end

  // Timer source: instruction clock or external edge
  assign timer_src_tick = opt_q[CS_BIT] ? ext_rise : (phase_q == 2'd3);

  // Shared prescaler
  always_comb begin
    ratio_mask = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(opt_q[PS_LSB +: 3])) ratio_mask[i] = 1'b1;
    end
  end

  logic psc_in;
  logic psc_clr;
  assign wdt_run = wdt_config_en | (gcr_q[GE_BIT] & (gcr_q[1:0] == 2'(GS_WDT_OVF)));
  assign wdt_tick = wdt_run & (wdt_base_q == 16'(WDT_BASE_CYC - 1));
  assign psc_in = prescaler_assign_bit ? wdt_tick : (timer_src_tick & ~sleep_q);
  assign psc_clr = prescaler_assign_bit ? wd_clr : (wr_en & (paddr == CNT_OFS));
  assign psc_out = psc_in & ((psc_q & ratio_mask) == ratio_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) psc_q <= 8'h00;
    else if (psc_clr) psc_q <= 8'h00;
    else if (psc_in) psc_q <= psc_q + 8'h01;
  end

  // Sampled prescaler output, or the raw edge when assigned to watchdog, on Q2 and Q4 in counter mode
  logic psc_hold_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) psc_hold_q <= 1'b0;
    else if (opt_q[CS_BIT] & phase_q[0]) psc_hold_q <= 1'b0;
    else if (opt_q[CS_BIT] & (prescaler_assign_bit ? (ext_rise & ~sleep_q) : psc_out)) psc_hold_q <= 1'b1;
  end

  // Edges seen on Q1/Q3 wait in psc_hold_q for the next sampling phase
  always_comb begin
    if (opt_q[CS_BIT]) begin
      timer_inc = phase_q[0] & (psc_hold_q | (prescaler_assign_bit ? (ext_rise & ~sleep_q) : psc_out));
    end else begin
      timer_inc = prescaler_assign_bit ? (timer_src_tick & ~sleep_q) : psc_out;
    end
  end
  assign overflow = timer_inc & (cnt_q == 8'hFF);

  always_comb begin
    cnt_d = cnt_q;
    if (wr_en & (paddr == CNT_OFS)) cnt_d = pwdata[7:0];
    else if (timer_inc) cnt_d = cnt_q + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 8'h00;
    else cnt_q <= cnt_d;
  end

  // Overflow flag: set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_q <= 1'b0;
    else if (overflow) flag_q <= 1'b1;
    else if (wr_en & (paddr == ICR_OFS)) flag_q <= pwdata[OVF_FLAG_BIT];
  end
  assign byte_timer_irq = flag_q & ie_q;

  // Watchdog base counter and counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_base_q <= 16'h0000;
      wdt_cnt_q <= 8'h00;
    end else if (wd_clr | ~wdt_run) begin
      wdt_base_q <= 16'h0000;
      wdt_cnt_q <= 8'h00;
    end else begin
      wdt_base_q <= wdt_tick ? 16'h0000 : wdt_base_q + 16'h0001;
      if (prescaler_assign_bit ? psc_out : wdt_tick) wdt_cnt_q <= wdt_cnt_q + 8'h01;
    end
  end
  assign wdt_ovf = wdt_run & (prescaler_assign_bit ? psc_out : wdt_tick) & (wdt_cnt_q == 8'hFF);
  assign wdt_osc_on = wdt_run;
  assign wdt_timeout = wdt_ovf & wdt_config_en;

  // Third timer
  assign t3_tick = t3_on_q & (phase_q == 2'd3);
  assign t3_reset = t3_tick & (t3_q == per_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) t3_q <= 8'h00;
    else if (t3_reset) t3_q <= 8'h00;
    else if (t3_tick) t3_q <= t3_q + 8'h01;
  end

  // Internal gate pulses registered and edge-detected
  logic ovf_p_q;
  logic match_p_q;
  logic wovf_p_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
      match_q <= 1'b0;
      wovf_q <= 1'b0;
      ovf_p_q <= 1'b0;
      match_p_q <= 1'b0;
      wovf_p_q <= 1'b0;
    end else begin
      ovf_q <= overflow;
      match_q <= t3_reset;
      wovf_q <= wdt_ovf;
      ovf_p_q <= ovf_q;
      match_p_q <= match_q;
      wovf_p_q <= wovf_q;
    end
  end
  assign ovf_rise = ovf_q & ~ovf_p_q;
  assign match_rise = match_q & ~match_p_q;
  assign wovf_rise = wovf_q & ~wovf_p_q;

  // Gate source mux and polarity
  always_comb begin
    unique case (gate_src_t'(gcr_q[GSS_LSB +: 2]))
      GS_PIN: gate_sel = pin_lvl;
      GS_BYTE_OVF: gate_sel = ovf_rise;
      GS_T3_MATCH: gate_sel = match_rise;
      GS_WDT_OVF: gate_sel = wovf_rise;
    endcase
  end
  assign gate_active = ~gcr_q[GE_BIT] | (gate_sel == gcr_q[GPOL_BIT]);

  // Second timer count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sec_q <= 16'h0000;
    else if (gcr_q[ON_BIT] & sclk_rise & gate_active) sec_q <= sec_q + 16'h0001;
  end
  assign second_count = sec_q;
endmodule : tmr_gate

// ---- dv/pin_model.sv ----
// Far-side pin driver: external count clock, second timer clock, gate pin.
// Assumes the bench drives the run and level controls just after pclk rises.
module pin_model (
  input wire logic pclk, // Clock
  input wire logic ext_run, // Run count clock
  input wire logic sclk_run, // Run second clock
  input wire logic gate_lvl, // Gate level
  output logic external_count_clock_pin = 1'b0, // Count clock pin
  output logic second_clk_pin = 1'b0, // Second clock pin
  output logic gate_input_pin = 1'b0 // Gate pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div_q = 4'h0;
  // Clocks stand low while stopped
  always_ff @(posedge pclk) begin
    div_q <= div_q + 4'h1;
    external_count_clock_pin <= ext_run & div_q[3];
    second_clk_pin <= sclk_run & div_q[1];
    gate_input_pin <= gate_lvl;
  end
endmodule : pin_model

// ---- dv/tmr_gate_asserts.sv ----
// Port checker for tmr_gate, bound to the design.
// Assumes register writes are seen on the APB ports.
module tmr_gate_asserts
  import tmr_gate_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic second_clk_pin, // Second clock
  input wire logic wdt_config_en, // Watchdog config
  input wire logic byte_timer_irq, // Irq
  input wire logic wdt_osc_on, // Osc request
  input wire logic wdt_timeout, // Timeout
  input wire logic [15:0] second_count // Count
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic ie_q;
  logic [8:0] gcr_q;
  assign wr = psel && penable && pwrite;
  // Shadow of enables written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= 1'b0;
      gcr_q <= 9'h000;
    end else if (wr && paddr == ICR_OFS) begin
      ie_q <= pwdata[OVF_IE_BIT];
    end else if (wr && paddr == GCR_OFS) begin
      gcr_q <= pwdata[8:0];
    end
  end
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable |-> pslverr == (paddr > STAT_OFS))
    else $error("pslverr wrong");
  a_irq_masked: assert property (!ie_q && !$past(ie_q) |-> !byte_timer_irq)
    else $error("irq while masked");
  a_flag_sticky: assert property ($fell(byte_timer_irq) |-> $past(wr) || $past(wr, 2))
    else $error("irq fell without write");
  a_osc_gate: assert property (gcr_q[GE_BIT] && gcr_q[1:0] == 2'b11 |-> wdt_osc_on)
    else $error("osc off");
  a_timeout_cfg: assert property (!wdt_config_en && !$past(wdt_config_en) |-> !wdt_timeout)
    else $error("timeout without config");
  a_count_step: assert property (second_count - $past(second_count) <= 16'h1)
    else $error("count jumped");
  a_count_hold: assert property ($stable(second_clk_pin) [*6] |=> $stable(second_count))
    else $error("count moved without clock");
endmodule : tmr_gate_asserts
bind tmr_gate tmr_gate_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .second_clk_pin, .wdt_config_en, .byte_timer_irq, .wdt_osc_on,
  .wdt_timeout, .second_count);

// ---- dv/tb.sv ----
// Self-checking bench for tmr_gate.
// Assumes pin_model drives the pins and the checker is bound.
module tb
  import tmr_gate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q, cnt_q, dl, edges;
  logic pready, pslverr, err_q, byte_timer_irq, wdt_osc_on, wdt_timeout;
  logic external_count_clock_pin, gate_input_pin, second_clk_pin;
  logic sleep_mode = 1'b0, wdt_config_en = 1'b0, ext_run = 1'b0, sclk_run = 1'b0, gate_lvl = 1'b0;
  logic [15:0] second_count;
  int mismatches = 0, samples_checked = 0;
  row_t rows [10] = '{'{1'b0, OPT_OFS, 32'h0, 32'hFF, 1'b0}, '{1'b0, CNT_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b0, ICR_OFS, 32'h0, 32'h0, 1'b0}, '{1'b0, GCR_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b0, T3_OFS, 32'h0, 32'hFF, 1'b0}, '{1'b0, STAT_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h01C, 32'h0, 32'h0, 1'b1}, '{1'b1, GCR_OFS, 32'h1C3, 32'h0, 1'b0},
    '{1'b0, GCR_OFS, 32'h0, 32'h1C3, 1'b0}, '{1'b1, 12'h020, 32'h5, 32'h0, 1'b1}};
  tmr_gate dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .external_count_clock_pin, .gate_input_pin, .second_clk_pin, .sleep_mode,
    .wdt_config_en, .byte_timer_irq, .wdt_osc_on, .wdt_timeout, .second_count);
  pin_model pins_u (.pclk, .ext_run, .sclk_run, .gate_lvl, .external_count_clock_pin,
    .second_clk_pin, .gate_input_pin);
  always #20 pclk = ~pclk;
  always @(posedge external_count_clock_pin) edges++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
    samples_checked++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic span();
    cnt_q = {16'h0, second_count};
    repeat (64) @(posedge pclk);
    dl = {16'h0, second_count} - cnt_q;
  endtask : span
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd_q, rows[i].x, 32'h0);
      chk({31'h0, err_q}, {31'h0, rows[i].e}, 32'h0);
    end
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OPT_OFS, (s == 3) ? 32'h08 : 32'(s));
      apb(1'b1, CNT_OFS, 32'h0);
      repeat (512) @(posedge pclk);
      apb(1'b0, CNT_OFS, 32'h0);
      chk(rd_q, (s == 3) ? 32'h80 : 32'h40 >> s, 32'h2);
    end
    $display("test prescaler done");
    apb(1'b1, OPT_OFS, 32'h08);
    apb(1'b1, CNT_OFS, 32'hFE);
    repeat (20) @(posedge pclk);
    apb(1'b0, ICR_OFS, 32'h0);
    chk(rd_q, 32'h04, 32'h0);
    chk({31'h0, byte_timer_irq}, 32'h0, 32'h0);
    apb(1'b1, ICR_OFS, 32'h24);
    repeat (2) @(posedge pclk);
    chk({31'h0, byte_timer_irq}, 32'h1, 32'h0);
    apb(1'b1, ICR_OFS, 32'h20);
    apb(1'b0, ICR_OFS, 32'h0);
    chk(rd_q, 32'h20, 32'h0);
    sleep_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, CNT_OFS, 32'h0);
    cnt_q = rd_q;
    repeat (100) @(posedge pclk);
    apb(1'b0, CNT_OFS, 32'h0);
    chk(rd_q, cnt_q, 32'h0);
    sleep_mode <= 1'b0;
    apb(1'b1, OPT_OFS, 32'h28);
    apb(1'b1, CNT_OFS, 32'h0);
    edges = 32'h0;
    ext_run <= 1'b1;
    repeat (160) @(posedge pclk);
    ext_run <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b0, CNT_OFS, 32'h0);
    chk(rd_q, edges, 32'h0);
    $display("test byte timer done");
    sclk_run <= 1'b1;
    apb(1'b1, GCR_OFS, 32'h100);
    span();
    chk(dl, 32'h10, 32'h2);
    for (int k = 0; k < 4; k++) begin
      gate_lvl <= k[0];
      apb(1'b1, GCR_OFS, 32'h180 | (32'(k[1]) << GPOL_BIT));
      repeat (8) @(posedge pclk);
      span();
      chk(dl, (k[0] == k[1]) ? 32'h10 : 32'h0, (k[0] == k[1]) ? 32'h2 : 32'h0);
    end
    for (int g = 1; g < 4; g++) begin
      apb(1'b1, GCR_OFS, 32'h180 | 32'(g));
      repeat (8) @(posedge pclk);
      chk({31'h0, wdt_osc_on}, 32'(g == 3), 32'h0);
      span();
      chk(dl, 32'h10, 32'h3);
    end
    $display("test gate done");
    apb(1'b1, T3_OFS, 32'h0001_0003);
    repeat (10) @(posedge pclk);
    apb(1'b0, T3_OFS, 32'h0);
    chk({24'h0, rd_q[15:8]}, 32'h1, 32'h2);
    chk({31'h0, wdt_timeout}, 32'h0, 32'h0);
    $display("test third timer done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({16'h0, second_count}, 32'h0, 32'h0);
    apb(1'b0, OPT_OFS, 32'h0);
    chk(rd_q, 32'hFF, 32'h0);
    apb(1'b0, GCR_OFS, 32'h0);
    chk(rd_q, 32'h0, 32'h0);
    $display("test reset done");
    end_of_test();
  end
endmodule : tb
